// ==== design/serial_bus_link_interrupt_flags.sv ====
// interrupt status, mask and summary logic of the serial-bus link layer
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
module serial_bus_link_interrupt_flags (
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_reset_n,
    input  wire irq_flags_pkg::reg_req_t         i_req,
    output logic [irq_flags_pkg::DATA_W-1:0]     o_rdata,
    input  wire irq_flags_pkg::link_events_t     i_events,
    input  wire logic                            i_selfid_stored,
    output logic                                 o_selfid_capture_enable,
    output logic                                 o_trigger_mode_enable,
    output logic                                 o_irq
);
    import irq_flags_pkg::*;

    // progress of one serial bus reset, gray coded along the usual path
    typedef enum logic [1:0] {
        RST_IDLE        = 2'b00,
        RST_ACTIVE      = 2'b01,
        RST_WAIT_STORED = 2'b11
    } bus_reset_state_t;

    // register state and its next values
    bus_reset_state_t rst_state;
    bus_reset_state_t next_rst_state;
    logic [31:0]      mask;
    logic [31:0]      next_mask;
    logic [31:0]      control;
    logic [31:0]      next_control;
    logic [31:0]      diag;
    logic [31:0]      next_diag;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic             summary_bit;
    logic             next_summary_bit;
    logic             rx_pending;
    logic             next_rx_pending;

    // decoded strobes and combined views
    logic [31:0]      status;
    logic [31:0]      set_vec;
    logic             status_wr;
    logic             mask_wr;
    logic             control_wr;
    logic             diag_wr;
    logic             diag_mode;
    logic             selfid_ready;
    logic             selfid_set;
    logic             rx_hold;
    logic             summary;

    // true when the request addresses the given register
    function automatic logic hit(input reg_req_t r, input logic [7:0] off);
        hit = (r.addr == off);
    endfunction

    // true for a write strobe to the given register
    function automatic logic write_to(input reg_req_t   r,
                                      input logic [7:0] off);
        write_to = r.wr && hit(r, off);
    endfunction

    // next value of one event flag: software write first, then the event,
    // so that an event in the clearing cycle is not lost
    function automatic logic flag_next(input logic cur,
                                       input logic wr_en,
                                       input logic wr_bit,
                                       input logic writable,
                                       input logic set);
        logic after_wr;
        if (!wr_en) begin
            after_wr = cur;
        end else if (writable) begin
            after_wr = wr_bit;
        end else begin
            after_wr = cur & ~wr_bit;
        end
        flag_next = after_wr | set;
    endfunction

    assign status_wr    = write_to(i_req, OFF_IRQ_STATUS);
    assign mask_wr      = write_to(i_req, OFF_IRQ_MASK);
    assign control_wr   = write_to(i_req, OFF_CONTROL);
    assign diag_wr      = write_to(i_req, OFF_DIAG);
    assign diag_mode    = diag[BIT_DIAG_WRITE];
    // with capture off nothing has to be waited for
    assign selfid_ready = !control[BIT_CTL_SELFID] || i_selfid_stored;
    assign rx_hold      = (rst_state != RST_IDLE) && !selfid_set;

    always_comb begin
        next_rst_state = rst_state;
        selfid_set     = 1'b0;
        case (rst_state)
            RST_IDLE: begin
                if (i_events.bus_reset_begin) begin
                    next_rst_state = RST_ACTIVE;
                end
            end
            RST_ACTIVE: begin
                if (i_events.bus_reset_done) begin
                    if (selfid_ready) begin
                        selfid_set     = 1'b1;
                        next_rst_state = RST_IDLE;
                    end else begin
                        next_rst_state = RST_WAIT_STORED;
                    end
                end
            end
            RST_WAIT_STORED: begin
                // capture on: wait until every self-ID packet is stored
                if (i_events.bus_reset_begin) begin
                    next_rst_state = RST_ACTIVE;
                end else if (selfid_ready) begin
                    selfid_set     = 1'b1;
                    next_rst_state = RST_IDLE;
                end
            end
            default: begin
                next_rst_state = RST_IDLE;
            end
        endcase
    end

    // state register of the bus reset tracker
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_state <= RST_IDLE;
        end else begin
            rst_state <= next_rst_state;
        end
    end

    // receive block held off during bus reset
    always_comb begin
        next_rx_pending = rx_pending;
        if (rx_hold) begin
            if (i_events.rx_block) begin
                next_rx_pending = 1'b1;
            end
        end else begin
            next_rx_pending = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_pending <= 1'b0;
        end else begin
            rx_pending <= next_rx_pending;
        end
    end

    // one set request per event bit
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[BIT_PHY_EVENT]    = i_events.phy_event;
        set_vec[BIT_PHY_REGVAL]   = i_events.phy_regval;
        set_vec[BIT_BUS_RESET]    = i_events.bus_reset_begin;
        set_vec[BIT_SELFID_DONE]  = selfid_set;
        set_vec[BIT_TX_IDLE]      = i_events.tx_idle;
        set_vec[BIT_RX_BLOCK]     = !rx_hold &&
                                    (i_events.rx_block || rx_pending);
        set_vec[BIT_REMOTE_RST]   = i_events.remote_reset;
        set_vec[BIT_ISO_BADFMT]   = i_events.iso_badfmt;
        set_vec[BIT_ASYNC_BADFMT] = i_events.async_badfmt;
    end

    for (genvar b = 1; b < 32; b++) begin : g_flag
        if (IMPLEMENTED[b]) begin : g_used
            logic flag;
            logic next_flag;
            always_comb begin
                next_flag = flag_next(flag, status_wr, i_req.wdata[b],
                                      diag_mode, set_vec[b]);
            end
            always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    flag <= STATUS_RESET[b];
                end else begin
                    flag <= next_flag;
                end
            end
            assign status[b] = flag;
        end else begin : g_reserved
            assign status[b] = 1'b0;
        end
    end

    // summary bit writable in diag mode, for one cycle
    always_comb begin
        next_summary_bit = 1'b0;
        if (status_wr && diag_mode) begin
            next_summary_bit = i_req.wdata[BIT_SUMMARY];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            summary_bit <= STATUS_RESET[BIT_SUMMARY];
        end else begin
            summary_bit <= next_summary_bit;
        end
    end

    // the stored bit only adds to the live summary, never replaces it
    assign status[BIT_SUMMARY] = summary_bit;

    assign summary = |(status & mask & IMPLEMENTED);

    always_comb begin
        next_mask    = mask;
        next_control = control;
        next_diag    = diag;
        if (mask_wr) begin
            next_mask = i_req.wdata;
        end
        if (control_wr) begin
            next_control = i_req.wdata;
        end
        if (diag_wr) begin
            next_diag = i_req.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask    <= MASK_RESET;
            control <= CONTROL_RESET;
            diag    <= DIAG_RESET;
        end else begin
            mask    <= next_mask;
            control <= next_control;
            diag    <= next_diag;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_req.rd) begin
            case (i_req.addr)
                OFF_IRQ_STATUS: begin
                    next_rdata = (status & IMPLEMENTED)
                               | {31'h0000_0000, summary | summary_bit};
                end
                OFF_IRQ_MASK: begin
                    next_rdata = mask;
                end
                OFF_CONTROL: begin
                    next_rdata = control;
                end
                OFF_DIAG: begin
                    next_rdata = diag;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_rdata                 = rdata;
    assign o_selfid_capture_enable = control[BIT_CTL_SELFID];
    assign o_trigger_mode_enable   = control[BIT_CTL_TRIGGER];
    assign o_irq = (summary | summary_bit) & mask[BIT_SUMMARY];
endmodule

// ==== design/irq_flags_pkg.sv ====
// package: offsets, bit positions and reset values of the interrupt block
package irq_flags_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFF_CONTROL     = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h10;
    localparam logic [7:0]  OFF_DIAG        = 8'h20;
    localparam int          BIT_SUMMARY     = 0;
    localparam int          BIT_PHY_EVENT   = 1;
    localparam int          BIT_PHY_REGVAL  = 2;
    localparam int          BIT_BUS_RESET   = 3;
    localparam int          BIT_SELFID_DONE = 4;
    localparam int          BIT_TX_IDLE     = 5;
    localparam int          BIT_RX_BLOCK    = 6;
    localparam int          BIT_REMOTE_RST  = 7;
    localparam int          BIT_ISO_BADFMT  = 11;
    localparam int          BIT_ASYNC_BADFMT = 12;
    localparam int          BIT_CTL_SELFID  = 1;
    localparam int          BIT_CTL_TRIGGER = 2;
    localparam int          BIT_DIAG_WRITE  = 0;
    // event bits that exist; reserved positions stay out
    localparam logic [31:0] IMPLEMENTED     = 32'h0000_18FE;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
    localparam logic [31:0] DIAG_RESET      = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic phy_event;
        logic phy_regval;
        logic bus_reset_begin;
        logic bus_reset_done;
        logic tx_idle;
        logic rx_block;
        logic remote_reset;
        logic iso_badfmt;
        logic async_badfmt;
    } link_events_t;
endpackage

// ==== verification/irq_flags_assertions.sv ====
// checker: port assertions of the interrupt flag block
module irq_flags_assertions
    import irq_flags_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_reset_n,
    input wire reg_req_t          i_req,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire link_events_t      i_events,
    input wire logic              i_selfid_stored,
    input wire logic              o_selfid_capture_enable,
    input wire logic              o_trigger_mode_enable,
    input wire logic              o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic st_rd = i_req.rd && i_req.addr == OFF_IRQ_STATUS;
    wire logic ct_wr = i_req.wr && i_req.addr == OFF_CONTROL;
    wire logic st_wr = i_req.wr && i_req.addr == OFF_IRQ_STATUS;
    AST_RESERVED_ZERO: assert property ($past(st_rd) |->
        (o_rdata & ~(IMPLEMENTED | 32'h1)) == '0) else $error("reserved set");
    AST_SUMMARY_OR: assert property ($past(st_rd) && o_rdata[0] &&
        !$past(st_wr, 2) |-> |o_rdata[31:1])
        else $error("summary without flag");
    AST_IRQ_SUMMARY: assert property (o_irq && st_rd |=> o_rdata[0])
        else $error("irq without summary");
    AST_PHY_SET: assert property (i_events.phy_event && !i_req.wr
        ##1 st_rd |=> o_rdata[BIT_PHY_EVENT]) else $error("phy flag lost");
    AST_REMOTE_SET: assert property (i_events.remote_reset && !i_req.wr
        ##1 st_rd |=> o_rdata[BIT_REMOTE_RST]) else $error("cmd flag lost");
    AST_ASYNC_SET: assert property (i_events.async_badfmt && !i_req.wr
        ##1 st_rd |=> o_rdata[BIT_ASYNC_BADFMT]) else $error("fmt flag lost");
    AST_CTL_WRITE: assert property ($past(ct_wr) |->
        o_selfid_capture_enable == $past(i_req.wdata[BIT_CTL_SELFID]) &&
        o_trigger_mode_enable == $past(i_req.wdata[BIT_CTL_TRIGGER]))
        else $error("control not taken");
    AST_CTL_HOLD: assert property (!$past(ct_wr) |->
        $stable(o_selfid_capture_enable) && $stable(o_trigger_mode_enable))
        else $error("control moved");
    COV_IRQ: cover property (o_irq);
    COV_SELFID: cover property (st_rd ##1 o_rdata[BIT_SELFID_DONE]);
    COV_CTL: cover property (ct_wr);
endmodule

bind serial_bus_link_interrupt_flags irq_flags_assertions u_chk (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .o_rdata(o_rdata), .i_events(i_events), .i_selfid_stored(i_selfid_stored),
    .o_selfid_capture_enable(o_selfid_capture_enable),
    .o_trigger_mode_enable(o_trigger_mode_enable), .o_irq(o_irq));

// ==== verification/link_event_source.sv ====
// partner model: event source on the phy and link side
module link_event_source
    import irq_flags_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic [8:0] i_fire,
    input  wire logic       i_stored,
    output link_events_t    o_events,
    output logic            o_selfid_stored
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_events = '0;
    initial o_selfid_stored = 1'b0;
    always @(posedge i_ref_clk) begin
        o_events <= link_events_t'(i_fire);
        o_selfid_stored <= i_stored;
    end
endmodule

// ==== verification/serial_bus_link_interrupt_flags_tb.sv ====
// testbench: interrupt flag block against a bench model
module serial_bus_link_interrupt_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_flags_pkg::*;
    logic         ref_clk = 0, reset_n = 0, stored = 0, sel, trg, irq, sid;
    reg_req_t     req = '0;
    logic [8:0]   fire = '0;
    link_events_t ev;
    logic [31:0]  rdata, v, flags = 0, mask = 0;
    int           err_total = 0, comparisons = 0, cyc = 0;
    int           pos[9] = '{1, 2, 5, 6, 7, 11, 12, 3, 4};
    int           idx[9] = '{8, 7, 4, 3, 2, 1, 0, 6, 5};
    serial_bus_link_interrupt_flags DUT (.i_ref_clk(ref_clk),
        .i_reset_n(reset_n), .i_req(req), .o_rdata(rdata), .i_events(ev),
        .i_selfid_stored(sid), .o_selfid_capture_enable(sel),
        .o_trigger_mode_enable(trg), .o_irq(irq));
    link_event_source partner (.i_ref_clk(ref_clk), .i_fire(fire),
        .i_stored(stored), .o_events(ev), .o_selfid_stored(sid));
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) req <= '0;
    endtask
    task automatic chk_st();
        @(posedge ref_clk) req <= '{OFF_IRQ_STATUS, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) req <= '0;
        #1 v = flags | {31'h0, |(flags & mask & 32'hFFFF_FFFE)};
        chk(rdata, v);
        chk({31'h0, irq}, {31'h0, v[0] & mask[0]});
    endtask
    task automatic fire_ev(int k);
        @(posedge ref_clk) fire <= 9'h1 << k;
        @(posedge ref_clk) fire <= '0;
    endtask
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc > 3000) begin
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(72311));
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        chk_st();
        mask = ($urandom & (IMPLEMENTED | 32'h1)) | 32'h1;
        wr(OFF_IRQ_MASK, mask);
        @(posedge ref_clk) req <= '{OFF_IRQ_MASK, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) req <= '0;
        #1 chk(rdata, mask);
        foreach (idx[i]) begin
            fire_ev(idx[i]);
            flags[pos[i]] = 1'b1;
            chk_st();
        end
        wr(OFF_IRQ_STATUS, flags);
        flags = 0;
        chk_st();
        fire_ev(6);
        fire_ev(3);
        flags[3] = 1'b1;
        chk_st();
        fire_ev(5);
        flags = flags | 32'h50;
        chk_st();
        wr(OFF_DIAG, 32'h1);
        v = $urandom;
        wr(OFF_IRQ_STATUS, v);
        flags = v & IMPLEMENTED;
        chk_st();
        wr(OFF_DIAG, 32'h0);
        v = $urandom;
        wr(OFF_CONTROL, v);
        #1 chk({30'h0, trg, sel}, {30'h0, v[2:1]});
        wr(OFF_IRQ_STATUS, 32'hFFFF_FFFF);
        wr(OFF_CONTROL, 32'h2);
        fire_ev(6);
        fire_ev(5);
        flags = 32'h8;
        chk_st();
        @(posedge ref_clk) stored <= 1'b1;
        @(posedge ref_clk);
        flags[4] = 1'b1;
        chk_st();
        mask = IMPLEMENTED;
        wr(OFF_IRQ_MASK, mask);
        chk_st();
        print_verdict();
    end
endmodule
